// ===== verif/lfa_bus_align_sva.sv
`timescale 1ns/1ps
module lfa_bus_align_chk (
  input wire sys_clk,
  input wire sys_rst,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire sampleTick,
  input wire chanAValid,
  input wire chanBValid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  chk_wait_req: assert property (avs_waitrequest |-> avs_read || avs_write)
    else $error("waitrequest without request");
  chk_rd_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait state");
  chk_wr_wait: assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("write not answered after one wait state");
  chk_ack_once: assert property ((avs_read || avs_write) && !avs_waitrequest
    |=> avs_waitrequest || !(avs_read || avs_write))
    else $error("request acknowledged twice");
  chk_rd_hold: assert property (!$past(avs_read) |-> $stable(avs_readdata))
    else $error("read data changed without a read");
  chk_a_tick: assert property (chanAValid |-> $past(sampleTick, 2))
    else $error("channel A sample without a tick");
  chk_b_tick: assert property (chanBValid |-> $past(sampleTick, 2))
    else $error("channel B sample without a tick");
  chk_b_with_a: assert property (chanBValid |-> chanAValid)
    else $error("channel B sample apart from channel A");
  cov_read: cover property (avs_read && !avs_waitrequest);
  cov_a: cover property (chanAValid && !chanBValid);
  cov_b: cover property (chanBValid);
endmodule

bind lfa_bus_align lfa_bus_align_chk chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .sampleTick(sampleTick), .chanAValid(chanAValid),
  .chanBValid(chanBValid));

// ===== verif/lfa_bus_align_tb.sv
`timescale 1ns/1ps
module lfa_bus_align_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic sampleTick = 1'b0;
  logic laneStrobeSelN = 1'b1;
  logic go = 1'b0;
  logic laneMode = 1'b0;
  logic [3:0] stbLane = 4'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [3:0] fc;
  wire [3:0] st;
  wire [11:0] ln [4];
  wire [11:0] chanAData;
  wire [11:0] chanBData;
  wire chanAValid;
  wire chanBValid;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic [4:0] rb [4];
  always #2.5 sys_clk = ~sys_clk;
  for (genvar g = 0; g < 4; g++) begin : src
    lfa_src_model #(.BUS(g)) m (.go(go), .laneMode(laneMode), .stbLane(stbLane),
      .fwdClk(fc[g]), .strobe(st[g]), .lanes(ln[g]));
  end
  lfa_bus_align uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_address(avs_address), .avs_byteenable(4'hF), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .busAFwdClock(fc[0]), .busBFwdClock(fc[1]), .busCFwdClock(fc[2]), .busDFwdClock(fc[3]),
    .busAStrobe(st[0]), .busBStrobe(st[1]), .busCStrobe(st[2]), .busDStrobe(st[3]),
    .busADataLanes(ln[0]), .busBDataLanes(ln[1]), .busCDataLanes(ln[2]),
    .busDDataLanes(ln[3]), .laneStrobeSelN(laneStrobeSelN), .sampleTick(sampleTick),
    .chanAData(chanAData), .chanBData(chanBData), .chanAValid(chanAValid),
    .chanBValid(chanBValid)
  );
  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(logic w, logic [5:0] a, logic [31:0] d);
    @(posedge sys_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function automatic logic [11:0] word(int b, int e, int lane, bit lm);
    logic [11:0] w;
    w = {4'(b + 1), 4'(e), 4'h5};
    if (lm) w[lane] = 1'b0;
    return w;
  endfunction
  task automatic run(int m, int dc, int d, bit lsb, bit sel, int wd, logic [3:0] en, bit smp);
    int n;
    int r;
    int slot;
    int ticks;
    bit lm;
    n = m == 2 ? 4 : (m == 0 ? 2 : 1);
    r = m == 2 ? 32 : (m == 0 ? 16 : 8) << dc;
    lm = lsb || !sel;
    bus(1, 6'h00, {20'h0, 4'(wd), en, lsb, dc[0], 2'(m)});
    bus(1, 6'h04, 32'(d));
    laneStrobeSelN <= sel;
    laneMode <= lm;
    stbLane <= 4'(12 - wd);
    repeat (4) @(posedge sys_clk);
    go <= 1'b1;
    repeat (160) @(posedge sys_clk);
    go <= 1'b0;
    bus(0, 6'h08, 32'h0);
    cmp("status", 32'h100 | 32'((r - d) % r), rd & 32'h0000011F);
    if (m == 2 && en == 4'hF) begin
      for (int k = 0; k < 4; k++) begin
        bus(0, 6'h10 + 6'(4 * k), 32'h0);
        rb[k] = rd[4:0];
      end
      for (int k = 0; k < 3; k++) cmp("readback step", 1, 5'(rb[k + 1] - rb[k]) <= 5'h02);
    end
    // Tick one at a time: the quarter-rate divider phase is unknown between runs
    for (int s = 0; s < r && smp; s++) begin
      ticks = 0;
      do begin
        @(posedge sys_clk) sampleTick <= 1'b1;
        @(posedge sys_clk) sampleTick <= 1'b0;
        repeat (2) @(negedge sys_clk);
        ticks++;
      end while (chanAValid !== 1'b1 && ticks < 8);
      slot = (s + r - d) % r;
      if (s > 0) cmp("ticks per sample", m == 1 ? 4 : 1, ticks);
      cmp("chan A", word(slot % n, slot / n, 12 - wd, lm), chanAData);
      cmp("chan B valid", m != 2, chanBValid);
      if (m != 2) cmp("chan B", word(2 + slot % n, slot / n, 12 - wd, lm), chanBData);
    end
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    bus(0, 6'h00, 32'h0);
    cmp("ctrl reset", 32'h00000CF0, rd);
    bus(0, 6'h04, 32'h0);
    cmp("delay reset", 32'h0, rd);
    bus(0, 6'h0C, 32'h0);
    cmp("unmapped", 32'h0, rd);
    run(2, 0, 0, 1'b0, 1'b1, 12, 4'hF, 1'b1);
    run(2, 0, 3, 1'b1, 1'b1, 10, 4'hF, 1'b1);
    run(0, 0, 0, 1'b0, 1'b0, 12, 4'hF, 1'b1);
    run(1, 0, 2, 1'b0, 1'b1, 12, 4'hF, 1'b1);
    run(2, 0, 5, 1'b0, 1'b1, 12, 4'hE, 1'b0);
    run(0, 1, 5, 1'b0, 1'b1, 12, 4'hF, 1'b0);
    run(1, 1, 5, 1'b0, 1'b1, 12, 4'hF, 1'b0);
    end_of_test();
  end
endmodule

// ===== verif/lfa_src_model.sv
`timescale 1ns/1ps
module lfa_src_model #(
  parameter BUS = 0
) (
  input wire go,
  input wire laneMode,
  input wire [3:0] stbLane,
  output reg fwdClk,
  output reg strobe,
  output reg [11:0] lanes
);
  integer i;
  initial begin
    fwdClk = 1'b0;
    strobe = 1'b0;
    lanes = 12'h000;
  end
  // All buses launch together: aligned clocks and strobes, skew far inside the FIFO
  always @(posedge go) begin
    // Keep link edges off the system clock edge so sampling never races
    #1;
    for (i = 0; i < 8; i = i + 1) begin
      lanes = {4'(BUS + 1), 4'(i), 4'h5};
      strobe = !laneMode && i == 0;
      if (laneMode) begin
        lanes[stbLane] = (i == 0);
      end
      #40 fwdClk = ~fwdClk;
      #40;
    end
    // Clock stands still; inverted lanes keep stale data from looking valid
    strobe = 1'b0;
    lanes = ~lanes;
  end
endmodule

// ===== verilog/lfa_bus_align.v
`timescale 1ns/1ps
`include "lfa_defines.vh"
module lfa_bus_align #(
  parameter LANES = `LFA_LANES,
  parameter DEPTH = `LFA_DEPTH
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire avs_read,
  input wire avs_write,
  input wire [5:0] avs_address,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire busAFwdClock,
  input wire busBFwdClock,
  input wire busCFwdClock,
  input wire busDFwdClock,
  input wire busAStrobe,
  input wire busBStrobe,
  input wire busCStrobe,
  input wire busDStrobe,
  input wire [LANES-1:0] busADataLanes,
  input wire [LANES-1:0] busBDataLanes,
  input wire [LANES-1:0] busCDataLanes,
  input wire [LANES-1:0] busDDataLanes,
  input wire laneStrobeSelN,
  input wire sampleTick,
  output reg [LANES-1:0] chanAData,
  output reg [LANES-1:0] chanBData,
  output reg chanAValid,
  output reg chanBValid
);
  localparam NB = `LFA_BUSES;
  localparam SYNC_W = NB * LANES + 2 * NB + 1;

  // Software state
  reg [1:0] modeSel_r;
  reg doubleClockEnable_r;
  reg lsbStrobeEn_r;
  reg [3:0] busEnCfg_r;
  reg [3:0] inputWidth_r;
  reg [`LFA_DLY_W-1:0] fifoReadDelay_r;
  reg ack_r;
  reg aligned_r;

  // Read side state
  reg [`LFA_DLY_W-1:0] rdCnt_r;
  reg [1:0] quarterCnt_r;
  reg advD_r;
  reg [1:0] selA_r;
  reg [1:0] selB_r;
  reg dualD_r;

  wire [SYNC_W-1:0] syncIn;
  wire [SYNC_W-1:0] syncOut;
  wire [NB*LANES-1:0] dataS;
  wire [NB-1:0] clkS;
  wire [NB-1:0] dedStrobeS;
  wire selNS;
  wire [1:0] modeEff;
  wire [NB-1:0] busEn;
  wire [`LFA_DLY_W-1:0] rangeMask;
  wire [1:0] shAmt;
  wire laneStrobeMode;
  wire [3:0] lsbIdx;
  wire [LANES-1:0] lsbMask;
  wire [NB-1:0] stbVec;
  wire [NB*`LFA_DLY_W-1:0] rbFlat;
  wire [NB*LANES-1:0] memOut;
  wire [`LFA_DLY_W-1:0] entryW;
  wire alignEvt;
  wire advance;
  wire [1:0] selA;
  wire [1:0] selB;
  wire dualChan;
  wire [`LFA_DLY_W-1:0] alignCnt;

  assign syncIn = {laneStrobeSelN,
                   busDStrobe, busCStrobe, busBStrobe, busAStrobe,
                   busDFwdClock, busCFwdClock, busBFwdClock, busAFwdClock,
                   busDDataLanes, busCDataLanes, busBDataLanes, busADataLanes};

  // Pins come from the forwarded-clock domains, so all pass two flops together
  lfa_sync2 #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .asyncIn(syncIn),
    .syncOut(syncOut)
  );

  assign dataS = syncOut[NB*LANES-1:0];
  assign clkS = syncOut[NB*LANES+NB-1:NB*LANES];
  assign dedStrobeS = syncOut[NB*LANES+2*NB-1:NB*LANES+NB];
  assign selNS = syncOut[SYNC_W-1];

  // Unused mode code behaves as two banks per channel
  assign modeEff = (modeSel_r == `LFA_MODE_ONE_BANK) ? `LFA_MODE_ONE_BANK :
                   (modeSel_r == `LFA_MODE_FOUR_BANKS) ? `LFA_MODE_FOUR_BANKS :
                   `LFA_MODE_TWO_BANKS;

  // Only buses A and C carry data with one bank per channel
  assign busEn = busEnCfg_r & ((modeEff == `LFA_MODE_ONE_BANK) ? 4'h5 : 4'hF);

  // Usable delay settings per mode
  assign rangeMask = (modeEff == `LFA_MODE_FOUR_BANKS) ? `LFA_MASK_0_31 :
                     (modeEff == `LFA_MODE_TWO_BANKS) ?
                       (doubleClockEnable_r ? `LFA_MASK_0_31 : `LFA_MASK_0_15) :
                       (doubleClockEnable_r ? `LFA_MASK_0_15 : `LFA_MASK_0_7);

  // Log2 of buses per channel: sample slot = entry * buses + position
  assign shAmt = (modeEff == `LFA_MODE_FOUR_BANKS) ? 2'h2 :
                 (modeEff == `LFA_MODE_TWO_BANKS) ? 2'h1 : 2'h0;

  assign laneStrobeMode = ~selNS | lsbStrobeEn_r;

  // Width is clamped so the strobe lane never leaves the bus
  assign lsbIdx = (inputWidth_r == 4'h0) ? 4'hB :
                  (inputWidth_r > 4'hC) ? 4'h0 : (4'hC - inputWidth_r);
  assign lsbMask = {{(LANES-1){1'b0}}, 1'b1} << lsbIdx;

  genvar b;
  generate
    for (b = 0; b < NB; b = b + 1) begin : g_bus
      localparam [31:0] POS_I = b;
      localparam [1:0] POS_ALL = POS_I[1:0];
      localparam [1:0] POS_PAIR = {1'b0, POS_I[0]};
      reg clkD_r;
      reg [`LFA_PTR_W-1:0] wrPtr_r;
      reg [`LFA_DLY_W-1:0] readback_r;
      wire rise;
      wire fall;
      wire [LANES-1:0] rawData;
      wire [LANES-1:0] pathData;
      wire strobeBit;
      wire stbEvt;
      wire wrEn;
      wire [`LFA_PTR_W-1:0] wrAddr;
      wire [1:0] posInChan;
      wire [`LFA_DLY_W-1:0] slot;

      assign rise = clkS[b] & ~clkD_r;
      assign fall = ~clkS[b] & clkD_r;
      assign rawData = dataS[b*LANES +: LANES];
      assign strobeBit = laneStrobeMode ? rawData[lsbIdx] : dedStrobeS[b];
      assign stbEvt = rise & strobeBit & busEn[b];
      assign pathData = laneStrobeMode ? (rawData & ~lsbMask) : rawData;
      assign wrEn = (rise | fall) & busEn[b];
      assign wrAddr = stbEvt ? {`LFA_PTR_W{1'b0}} : wrPtr_r;
      assign posInChan = (modeEff == `LFA_MODE_FOUR_BANKS) ? POS_ALL :
                         (modeEff == `LFA_MODE_TWO_BANKS) ? POS_PAIR : 2'h0;
      assign slot = (({1'b0, wrAddr} << shAmt) | {3'h0, posInChan}) & rangeMask;
      assign stbVec[b] = stbEvt;
      assign rbFlat[b*`LFA_DLY_W +: `LFA_DLY_W] = readback_r;

      // DDR capture: both forwarded-clock edges write one word
      always @(posedge sys_clk) begin
        if (sys_rst) begin
          clkD_r <= 1'b0;
          wrPtr_r <= {`LFA_PTR_W{1'b0}};
          readback_r <= {`LFA_DLY_W{1'b0}};
        end else begin
          clkD_r <= clkS[b];
          if (wrEn) begin
            wrPtr_r <= wrAddr + 1'b1;
            // Delay at which this word would be read the moment it lands
            readback_r <= (slot - rdCnt_r) & rangeMask;
          end
        end
      end

      lfa_fifo_mem #(
        .WIDTH(LANES),
        .DEPTH(DEPTH),
        .AW(`LFA_PTR_W)
      ) u_mem (
        .sys_clk(sys_clk),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(pathData),
        .rdAddr(entryW[`LFA_PTR_W-1:0]),
        .rdData(memOut[b*LANES +: LANES])
      );
    end
  endgenerate

  // Single reference strobe for the whole chip
  assign alignEvt = busEn[0] ? stbVec[0] : stbVec[2];
  assign alignCnt = ({`LFA_DLY_W{1'b0}} - fifoReadDelay_r) & rangeMask;

  // Sample rate is one quarter of the tick rate with one bank per channel
  assign advance = sampleTick &
                   ((modeEff != `LFA_MODE_ONE_BANK) || (quarterCnt_r == 2'h3));

  assign entryW = rdCnt_r >> shAmt;

  // Alphabetical bus order; later buses of a channel wait for their turn
  assign selA = (modeEff == `LFA_MODE_FOUR_BANKS) ? rdCnt_r[1:0] :
                (modeEff == `LFA_MODE_TWO_BANKS) ? {1'b0, rdCnt_r[0]} : 2'h0;
  assign selB = (modeEff == `LFA_MODE_TWO_BANKS) ? {1'b1, rdCnt_r[0]} : 2'h2;
  assign dualChan = (modeEff != `LFA_MODE_FOUR_BANKS);

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      rdCnt_r <= {`LFA_DLY_W{1'b0}};
      quarterCnt_r <= 2'h0;
      aligned_r <= 1'b0;
      advD_r <= 1'b0;
      selA_r <= 2'h0;
      selB_r <= 2'h0;
      dualD_r <= 1'b0;
    end else begin
      if (sampleTick) begin
        quarterCnt_r <= quarterCnt_r + 1'b1;
      end
      // Alignment wins over a same-cycle advance
      if (alignEvt) begin
        rdCnt_r <= alignCnt;
        aligned_r <= 1'b1;
      end else if (advance) begin
        rdCnt_r <= (rdCnt_r + 1'b1) & rangeMask;
      end
      advD_r <= advance;
      selA_r <= selA;
      selB_r <= selB;
      dualD_r <= dualChan;
    end
  end

  // Memory output is registered, so the channel word appears two edges after the tick
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      chanAData <= {LANES{1'b0}};
      chanBData <= {LANES{1'b0}};
      chanAValid <= 1'b0;
      chanBValid <= 1'b0;
    end else begin
      chanAValid <= advD_r;
      chanBValid <= advD_r & dualD_r;
      if (advD_r) begin
        chanAData <= memOut[selA_r*LANES +: LANES];
        if (dualD_r) begin
          chanBData <= memOut[selB_r*LANES +: LANES];
        end
      end
    end
  end

  // Avalon-MM slave: one wait state, answer on the second edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h00000000;
      modeSel_r <= `LFA_RST_MODE;
      doubleClockEnable_r <= `LFA_RST_DCM;
      lsbStrobeEn_r <= `LFA_RST_LSBSTB;
      busEnCfg_r <= `LFA_RST_BUSEN;
      inputWidth_r <= `LFA_RST_WIDTH;
      fifoReadDelay_r <= `LFA_RST_DELAY;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
      // A write lands only at the edge where waitrequest is seen low
      if (avs_write & ack_r) begin
        if (avs_address == `LFA_OFF_CTRL) begin
          if (avs_byteenable[0]) begin
            modeSel_r <= avs_writedata[`LFA_CTRL_MODE_LO +: 2];
            doubleClockEnable_r <= avs_writedata[`LFA_CTRL_DCM_BIT];
            lsbStrobeEn_r <= avs_writedata[`LFA_CTRL_LSBSTB_BIT];
            busEnCfg_r <= avs_writedata[`LFA_CTRL_BUSEN_LO +: 4];
          end
          if (avs_byteenable[1]) begin
            inputWidth_r <= avs_writedata[`LFA_CTRL_WIDTH_LO +: 4];
          end
        end
        if ((avs_address == `LFA_OFF_DELAY) && avs_byteenable[0]) begin
          fifoReadDelay_r <= avs_writedata[`LFA_DLY_W-1:0];
        end
      end
      if (avs_read & ~ack_r) begin
        case (avs_address)
          `LFA_OFF_CTRL: begin
            avs_readdata <= {20'h00000, inputWidth_r, busEnCfg_r,
                             lsbStrobeEn_r, doubleClockEnable_r, modeSel_r};
          end
          `LFA_OFF_DELAY: begin
            avs_readdata <= {27'h0000000, fifoReadDelay_r};
          end
          `LFA_OFF_STATUS: begin
            avs_readdata <= {23'h000000, aligned_r, 3'h0, rdCnt_r};
          end
          `LFA_OFF_RB0: begin
            avs_readdata <= {27'h0000000, rbFlat[4:0]};
          end
          `LFA_OFF_RB1: begin
            avs_readdata <= {27'h0000000, rbFlat[9:5]};
          end
          `LFA_OFF_RB2: begin
            avs_readdata <= {27'h0000000, rbFlat[14:10]};
          end
          `LFA_OFF_RB3: begin
            avs_readdata <= {27'h0000000, rbFlat[19:15]};
          end
          default: begin
            avs_readdata <= 32'h00000000;
          end
        endcase
      end
    end
  end
endmodule

// ===== verilog/lfa_defines.vh
`ifndef LFA_DEFINES_VH
`define LFA_DEFINES_VH

`define LFA_LANES 12
`define LFA_BUSES 4
`define LFA_DEPTH 16
`define LFA_PTR_W 4
`define LFA_DLY_W 5

`define LFA_MODE_TWO_BANKS 2'h0
`define LFA_MODE_ONE_BANK 2'h1
`define LFA_MODE_FOUR_BANKS 2'h2

`define LFA_MASK_0_31 5'h1F
`define LFA_MASK_0_15 5'h0F
`define LFA_MASK_0_7 5'h07

`define LFA_OFF_CTRL 6'h00
`define LFA_OFF_DELAY 6'h04
`define LFA_OFF_STATUS 6'h08
`define LFA_OFF_RB0 6'h10
`define LFA_OFF_RB1 6'h14
`define LFA_OFF_RB2 6'h18
`define LFA_OFF_RB3 6'h1C

`define LFA_CTRL_MODE_LO 0
`define LFA_CTRL_DCM_BIT 2
`define LFA_CTRL_LSBSTB_BIT 3
`define LFA_CTRL_BUSEN_LO 4
`define LFA_CTRL_WIDTH_LO 8

`define LFA_RST_MODE 2'h0
`define LFA_RST_DCM 1'b0
`define LFA_RST_LSBSTB 1'b0
`define LFA_RST_BUSEN 4'hF
`define LFA_RST_WIDTH 4'hC
`define LFA_RST_DELAY 5'h00

`define LFA_STAT_ALIGNED_BIT 8

`endif

// ===== verilog/lfa_fifo_mem.v
`timescale 1ns/1ps
module lfa_fifo_mem #(
  parameter WIDTH = 12,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire sys_clk,
  input wire wrEn,
  input wire [AW-1:0] wrAddr,
  input wire [WIDTH-1:0] wrData,
  input wire [AW-1:0] rdAddr,
  output reg [WIDTH-1:0] rdData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule

// ===== verilog/lfa_sync2.v
`timescale 1ns/1ps
module lfa_sync2 #(
  parameter WIDTH = 1
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire [WIDTH-1:0] asyncIn,
  output reg [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_r <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else begin
      meta_r <= asyncIn;
      syncOut <= meta_r;
    end
  end
endmodule
